// ==== src/mdp_ctrl.sv ====
`timescale 1ns/1ps
`include "mdp_map.svh"
module mdp_ctrl (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  output logic             init_done,
  output logic             req_ready,
  input  wire logic        wr_req,
  input  wire logic        rd_req,
  input  wire logic [1:0]  req_bank,
  input  wire logic [11:0] req_row,
  input  wire logic [8:0]  req_col,
  input  wire logic [63:0] wr_data,
  input  wire logic [7:0]  wr_mask,
  output logic [63:0]      rd_data,
  output logic             rd_valid,
  output logic             rd_strobe_seen,
  output logic             mem_clk_p,
  output logic             mem_clk_n,
  output logic             mem_cke,
  output logic             mem_cs_n,
  output logic             mem_ras_n,
  output logic             mem_cas_n,
  output logic             mem_we_n,
  output logic [12:0]      mem_addr,
  output logic [1:0]       mem_bank,
  input  wire logic [15:0] mem_dq_in,
  output logic [15:0]      mem_dq_out,
  output logic             mem_dq_oe_n,
  input  wire logic        lower_byte_data_strobe_in,
  output logic             lower_byte_data_strobe_out,
  output logic             lower_byte_data_strobe_oe_n,
  input  wire logic        upper_byte_data_strobe_in,
  output logic             upper_byte_data_strobe_out,
  output logic             upper_byte_data_strobe_oe_n,
  output logic             lower_byte_write_mask,
  output logic             upper_byte_write_mask
);
  mdp_pkg::mdp_regs_s r;
  mdp_pkg::mdp_regs_s next_r;
  logic [15:0]        dq_s;
  logic [1:0]         dqs_s, dqs_pin;
  logic               tick;
  logic               req_take;
  // clocks waited after a command issued on a tick edge
  function automatic logic [11:0] mck_wait(input int n);
    return 12'(2 * n - 1);
  endfunction
  // ==========================================
  // byte lane input capture
  assign dqs_pin = {upper_byte_data_strobe_in, lower_byte_data_strobe_in};
  for (genvar g = 0; g < 2; g++) begin : g_lane
    // one sampler per lane, each data line its own pin
    mdp_pin_sync u_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .ce       (ce),
      .pin_in   ({dqs_pin[g], mem_dq_in[8*g +: 8]}),
      .pin_sync ({dqs_s[g], dq_s[8*g +: 8]})
    );
  end
  // ==========================================
  // sequencer
  // memory clock is clk divided by two; commands change on falling mem clock
  assign tick     = r.clk_p;
  assign req_take = r.req_ready & (wr_req | rd_req);
  // next value of every register, one memory clock per two clk
  always_comb begin
    logic ref_set, ref_clr;
    ref_set       = 1'b0;
    ref_clr       = 1'b0;
    next_r        = r;
    next_r.clk_p  = ~r.clk_p;
    next_r.clk_n  = r.clk_p;
    next_r.rd_valid = 1'b0;
    next_r.cnt    = (r.cnt != 12'h0000) ? r.cnt - 12'h0001 : 12'h0000;
    // a command lasts exactly one memory clock
    next_r.cmd    = tick ? mdp_pkg::cmd_pins(mdp_pkg::cmd_nop) : r.cmd;
    // refresh interval timer, rounded down so rows never starve
    if (r.init_done) begin
      ref_set        = r.ref_cnt == 8'(`MDP_REF_CLKS - 1);
      next_r.ref_cnt = ref_set ? 8'h00 : r.ref_cnt + 8'h01;
    end
    case (r.st)
      mdp_pkg::st_pwr: begin
        if (tick && r.cnt == 12'h0000) begin
          next_r.cke = 1'b1;
          next_r.cnt = mck_wait(1);
          next_r.st  = mdp_pkg::st_pall;
        end
      end
      mdp_pkg::st_pall: begin
        if (tick && r.cnt == 12'h0000) begin
          next_r.cmd  = mdp_pkg::cmd_pins(mdp_pkg::cmd_pre);
          next_r.addr = `MDP_ALLBANK_ADDR;
          next_r.cnt  = mck_wait(`MDP_TRP_MCK);
          next_r.nref = `MDP_INIT_REFS;
          next_r.st   = mdp_pkg::st_iref;
        end
      end
      mdp_pkg::st_iref: begin
        if (tick && r.cnt == 12'h0000) begin
          next_r.cmd  = mdp_pkg::cmd_pins(mdp_pkg::cmd_ref);
          next_r.cnt  = mck_wait(`MDP_TRFC_MCK);
          next_r.nref = r.nref - 2'h1;
          next_r.st   = (r.nref == 2'h1) ? mdp_pkg::st_lmr : mdp_pkg::st_iref;
        end
      end
      mdp_pkg::st_lmr: begin
        if (tick && r.cnt == 12'h0000) begin
          next_r.cmd  = mdp_pkg::cmd_pins(mdp_pkg::cmd_lmr);
          next_r.ba   = `MDP_MODE_BANK;
          next_r.addr = `MDP_MODE_VAL;
          next_r.cnt  = mck_wait(`MDP_TMRD_MCK);
          next_r.st   = mdp_pkg::st_emr;
        end
      end
      mdp_pkg::st_emr: begin
        if (tick && r.cnt == 12'h0000) begin
          next_r.cmd       = mdp_pkg::cmd_pins(mdp_pkg::cmd_lmr);
          next_r.ba        = `MDP_EMR_BANK;
          next_r.addr      = `MDP_EMODE_VAL;
          next_r.cnt       = mck_wait(`MDP_TMRD_MCK);
          next_r.init_done = 1'b1;
          next_r.st        = mdp_pkg::st_idle;
        end
      end
      mdp_pkg::st_idle: begin
        // an advertised ready is honoured before a pending refresh
        if (req_take) begin
          next_r.is_wr = wr_req;
          next_r.bank  = req_bank;
          next_r.row   = req_row;
          next_r.col   = {req_col[8:2], 2'h0};
          next_r.wbuf  = wr_data;
          next_r.wmask = wr_mask;
          next_r.st    = mdp_pkg::st_act;
        end else if (tick && r.cnt == 12'h0000 && r.ref_due) begin
          next_r.cmd = mdp_pkg::cmd_pins(mdp_pkg::cmd_ref);
          next_r.cnt = mck_wait(`MDP_TRFC_MCK);
          ref_clr    = 1'b1;
        end
      end
      mdp_pkg::st_act: begin
        if (tick && r.cnt == 12'h0000) begin
          next_r.cmd  = mdp_pkg::cmd_pins(mdp_pkg::cmd_act);
          next_r.ba   = r.bank;
          next_r.addr = {1'b0, r.row};
          next_r.cnt  = mck_wait(`MDP_TRCD_MCK);
          next_r.st   = mdp_pkg::st_rw;
        end
      end
      mdp_pkg::st_rw: begin
        if (tick && r.cnt == 12'h0000) begin
          next_r.cmd  = r.is_wr ? mdp_pkg::cmd_pins(mdp_pkg::cmd_write) : mdp_pkg::cmd_pins(mdp_pkg::cmd_read);
          next_r.ba   = r.bank;
          next_r.addr = {4'h0, r.col};
          next_r.beat = 4'h0;
          next_r.st   = r.is_wr ? mdp_pkg::st_wdata : mdp_pkg::st_rdata;
        end
      end
      mdp_pkg::st_wdata: begin
        // preamble, four beats with strobe toggling, then release
        next_r.beat = r.beat + 4'h1;
        if (r.beat == `MDP_WR_PRE_BEAT) begin
          next_r.dq_oe_n = 1'b0;
          next_r.dqs     = 1'b0;
        end else if (r.beat == `MDP_WR_LAST_BEAT) begin
          next_r.dq_oe_n = 1'b1;
          next_r.dqs     = 1'b0;
          next_r.dm      = 2'h0;
          next_r.cnt     = mck_wait(`MDP_TWR_MCK);
          next_r.st      = mdp_pkg::st_pre;
        end else if (r.beat > `MDP_WR_PRE_BEAT) begin
          next_r.dq    = r.wbuf[15:0];
          next_r.dm    = r.wmask[1:0];
          next_r.dqs   = ~r.beat[0];
          next_r.wbuf  = {16'h0000, r.wbuf[63:16]};
          next_r.wmask = {2'h0, r.wmask[7:2]};
        end
      end
      mdp_pkg::st_rdata: begin
        // fixed capture window: latency plus sampler delay
        next_r.beat = r.beat + 4'h1;
        next_r.rbuf = (r.beat >= 4'(`MDP_RD_CAP_BEAT)) ? {dq_s, r.rbuf[63:16]} : r.rbuf;
        next_r.strobe_seen = (r.beat == 4'(`MDP_RD_CAP_BEAT)) ? &dqs_s : r.strobe_seen;
        if (r.beat == 4'(`MDP_RD_CAP_BEAT + 3)) begin
          next_r.rd_valid = 1'b1;
          next_r.cnt      = 12'h0000;
          next_r.st       = mdp_pkg::st_pre;
        end
      end
      mdp_pkg::st_pre: begin
        if (tick && r.cnt == 12'h0000) begin
          next_r.cmd  = mdp_pkg::cmd_pins(mdp_pkg::cmd_pre);
          next_r.addr = `MDP_ALLBANK_ADDR;
          next_r.cnt  = mck_wait(`MDP_TRP_MCK);
          next_r.st   = mdp_pkg::st_idle;
        end
      end
      default: begin
        next_r.st = mdp_pkg::st_idle;
      end
    endcase
    // a timer event in the clearing cycle is kept
    next_r.ref_due   = ref_set | (r.ref_due & ~ref_clr);
    next_r.req_ready = (next_r.st == mdp_pkg::st_idle) & next_r.init_done & ~next_r.ref_due;
  end
  // ==========================================
  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r         <= '0;
      r.st      <= mdp_pkg::st_pwr;
      r.cnt     <= 12'(`MDP_PWRUP_CLKS - 1);
      r.clk_n   <= 1'b1;
      r.cmd     <= mdp_pkg::cmd_pins(mdp_pkg::cmd_nop);
      r.dq_oe_n <= 1'b1;
    end else if (ce) begin
      r <= next_r;
    end
  end
  // ==========================================
  // outputs, all straight from the state register
  assign {init_done, req_ready, rd_valid, rd_strobe_seen} = {r.init_done, r.req_ready, r.rd_valid, r.strobe_seen};
  assign rd_data                     = r.rbuf;
  assign {mem_clk_p, mem_clk_n, mem_cke} = {r.clk_p, r.clk_n, r.cke};
  assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = r.cmd;
  assign {mem_addr, mem_bank}        = {r.addr, r.ba};
  assign {mem_dq_out, mem_dq_oe_n}   = {r.dq, r.dq_oe_n};
  assign {lower_byte_data_strobe_out, upper_byte_data_strobe_out} = {2{r.dqs}};
  assign {lower_byte_data_strobe_oe_n, upper_byte_data_strobe_oe_n} = {2{r.dq_oe_n}};
  assign {upper_byte_write_mask, lower_byte_write_mask} = r.dm;
  // ==========================================
  // checks
  logic [8:0] since_ref;
  wire        is_act = r.cmd == mdp_pkg::cmd_pins(mdp_pkg::cmd_act);
  wire        is_rd  = r.cmd == mdp_pkg::cmd_pins(mdp_pkg::cmd_read);
  wire        is_rw  = is_rd | (r.cmd == mdp_pkg::cmd_pins(mdp_pkg::cmd_write));
  wire        is_pre = r.cmd == mdp_pkg::cmd_pins(mdp_pkg::cmd_pre);
  wire        is_ref = r.cmd == mdp_pkg::cmd_pins(mdp_pkg::cmd_ref);
  wire        is_lmr = r.cmd == mdp_pkg::cmd_pins(mdp_pkg::cmd_lmr);
  // clocks since the last refresh command, saturating
  always_ff @(posedge clk) begin
    if (sys_rst || is_ref) begin
      since_ref <= 9'h000;
    end else if (ce && since_ref != 9'h1ff) begin
      since_ref <= since_ref + 9'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_clk_pair: assert property (mem_clk_p != mem_clk_n)
    else $error("memory clock pair not complementary");
  a_clk_toggle: assert property (ce |=> mem_clk_p != $past(mem_clk_p))
    else $error("memory clock failed to toggle");
  a_no_early_rw: assert property (!init_done |-> !is_rw)
    else $error("read or write before initialisation");
  a_act_to_rw: assert property ((is_act && !$past(is_act)) |-> ##1 (!is_rw)[*5])
    else $error("column command too soon after activate");
  a_pre_to_act: assert property ((is_pre && !$past(is_pre)) |-> ##1 (!(is_act || is_ref))[*5])
    else $error("activate or refresh too soon after precharge");
  a_mode_value: assert property ((is_lmr && mem_bank == `MDP_MODE_BANK) |-> mem_addr == `MDP_MODE_VAL)
    else $error("mode word not burst four latency three");
  a_row_range: assert property (is_act |-> !mem_addr[12])
    else $error("row beyond addressable range");
  a_lane_oe: assert property (lower_byte_data_strobe_oe_n == mem_dq_oe_n
                              && upper_byte_data_strobe_oe_n == mem_dq_oe_n)
    else $error("byte lane drive enables disagree");
  a_rd_latency: assert property ((is_rd && !$past(is_rd) && ce) ##1 ce[*8] ##1 ce[*4] |=> rd_valid)
    else $error("read data not returned on time");
  a_ref_gap: assert property (init_done |-> since_ref <= 9'(`MDP_REF_CLKS + `MDP_REF_SLACK))
    else $error("refresh interval exceeded");
  c_write: cover property (is_act ##[1:20] (mem_dq_oe_n == 1'b0));
  c_read: cover property (rd_valid);
  c_refresh: cover property (init_done && is_ref);
  c_init: cover property ($rose(init_done));
endmodule

// ==== src/mdp_map.svh ====
`ifndef MDP_MAP_SVH
`define MDP_MAP_SVH
// ==========================================
// clock and timing counts
`define MDP_CLK_NS        100
`define MDP_PWRUP_US      200
`define MDP_PWRUP_CLKS    ((`MDP_PWRUP_US * 1000 + `MDP_CLK_NS - 1) / `MDP_CLK_NS)
`define MDP_REF_MS        64
`define MDP_ROWS          4096
`define MDP_REF_CLKS      ((`MDP_REF_MS * 1000000 / `MDP_ROWS) / `MDP_CLK_NS)
`define MDP_REF_SLACK     64
`define MDP_TRCD_MCK      3
`define MDP_TRP_MCK       3
`define MDP_CL_MCK        3
`define MDP_TRFC_MCK      2
`define MDP_TMRD_MCK      2
`define MDP_TWR_MCK       2
`define MDP_INIT_REFS     2'h2
// ==========================================
// mode words and address fields
`define MDP_MODE_VAL      13'h0032
`define MDP_EMODE_VAL     13'h0000
`define MDP_MODE_BANK     2'h0
`define MDP_EMR_BANK      2'h2
`define MDP_ALLBANK_ADDR  13'h0400
// ==========================================
// data beat positions inside a burst
`define MDP_WR_PRE_BEAT   4'h1
`define MDP_WR_LAST_BEAT  4'h6
`define MDP_RD_CAP_BEAT   (`MDP_CL_MCK * 2 + 3)
`endif

// ==== src/mdp_pin_sync.sv ====
`timescale 1ns/1ps
// ==========================================
// two-stage synchroniser for one byte lane plus its strobe
module mdp_pin_sync (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic [8:0] pin_in,
  output logic      [8:0] pin_sync
);
  mdp_pkg::mdp_sync_s r;
  mdp_pkg::mdp_sync_s next_r;

  // first stage feeds only the second stage
  always_comb begin
    next_r    = r;
    next_r.s1 = pin_in;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign pin_sync = r.s2;
endmodule

// ==== src/mdp_pkg.sv ====
package mdp_pkg;
  typedef enum logic [3:0] {
    st_pwr, st_pall, st_iref, st_lmr, st_emr, st_idle,
    st_act, st_rw, st_wdata, st_rdata, st_pre
  } mdp_state_e;

  typedef enum logic [2:0] {
    cmd_nop, cmd_act, cmd_read, cmd_write, cmd_pre, cmd_ref, cmd_lmr
  } mdp_cmd_e;

  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
  } mdp_sync_s;

  typedef struct packed {
    mdp_state_e  st;
    logic [11:0] cnt;
    logic [7:0]  ref_cnt;
    logic        ref_due;
    logic [1:0]  nref;
    logic [3:0]  beat;
    logic [1:0]  bank;
    logic [11:0] row;
    logic [8:0]  col;
    logic        is_wr;
    logic [63:0] wbuf;
    logic [7:0]  wmask;
    logic [63:0] rbuf;
    logic        rd_valid;
    logic        strobe_seen;
    logic        init_done;
    logic        req_ready;
    logic        clk_p;
    logic        clk_n;
    logic        cke;
    logic [3:0]  cmd;
    logic [12:0] addr;
    logic [1:0]  ba;
    logic [15:0] dq;
    logic [1:0]  dm;
    logic        dq_oe_n;
    logic        dqs;
  } mdp_regs_s;

  // {cs_n, ras_n, cas_n, we_n} for each command
  function automatic logic [3:0] cmd_pins(input mdp_cmd_e c);
    case (c)
      cmd_act:   return 4'h3;
      cmd_read:  return 4'h5;
      cmd_write: return 4'h4;
      cmd_pre:   return 4'h2;
      cmd_ref:   return 4'h1;
      cmd_lmr:   return 4'h0;
      default:   return 4'h7;
    endcase
  endfunction
endpackage

// ==== tb/mdp_ctrl_bench.sv ====
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the pattern memory controller
module mdp_ctrl_bench;
  logic        clk, sys_rst, ce, rand_ce, wr_req, rd_req, init_done, req_ready, rd_valid, rd_strobe_seen;
  logic        mem_clk_p, mem_clk_n, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_dq_oe_n;
  logic [1:0]  req_bank, mem_bank, dqs_in, dqs_out, dqs_oe_n, wmask;
  logic [11:0] req_row;
  logic [8:0]  req_col;
  logic [63:0] wr_data, rd_data, got;
  logic [7:0]  wr_mask;
  logic [12:0] mem_addr;
  logic [15:0] mem_dq_in, mem_dq_out;
  logic [63:0] shadow [logic [20:0]];
  int          error_cnt, samples_checked, viol, rd_cmds, wr_cmds, seed, n, k;

  mdp_ctrl dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .init_done(init_done), .req_ready(req_ready),
    .wr_req(wr_req), .rd_req(rd_req), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
    .wr_data(wr_data), .wr_mask(wr_mask), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_strobe_seen(rd_strobe_seen), .mem_clk_p(mem_clk_p), .mem_clk_n(mem_clk_n), .mem_cke(mem_cke),
    .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
    .mem_addr(mem_addr), .mem_bank(mem_bank), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out),
    .mem_dq_oe_n(mem_dq_oe_n), .lower_byte_data_strobe_in(dqs_in[0]), .lower_byte_data_strobe_out(dqs_out[0]),
    .lower_byte_data_strobe_oe_n(dqs_oe_n[0]), .upper_byte_data_strobe_in(dqs_in[1]),
    .upper_byte_data_strobe_out(dqs_out[1]), .upper_byte_data_strobe_oe_n(dqs_oe_n[1]),
    .lower_byte_write_mask(wmask[0]), .upper_byte_write_mask(wmask[1]));

  mdp_mem_model mem (.clk(clk), .mem_clk_p(mem_clk_p), .mem_clk_n(mem_clk_n), .mem_cke(mem_cke),
    .cmd_pins({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}), .mem_addr(mem_addr), .mem_bank(mem_bank),
    .mem_dq_out(mem_dq_out), .mem_dq_oe_n(mem_dq_oe_n), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n),
    .wmask(wmask), .mem_dq_in(mem_dq_in), .dqs_in(dqs_in), .viol(viol), .rd_cmds(rd_cmds), .wr_cmds(wr_cmds));

  // ==========================================
  // 100 ns clock; enable thinned out at random when asked, to test freezing
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) ce <= rand_ce ? ($random(seed) % 4 != 0) : 1'b1;

  // expected word: masked bytes keep the old contents
  function automatic logic [63:0] merge(input logic [63:0] old, input logic [63:0] nw, input logic [7:0] m);
    merge = old;
    for (int b = 0; b < 8; b++) if (!m[b]) merge[b*8 +: 8] = nw[b*8 +: 8];
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic timeout();
    error_cnt++;
    $display("wrong value at %0t: wait ran out", $time);
    final_report();
  endtask

  // ==========================================
  // one request, held until taken; a read is compared with the shadow copy
  task automatic xfer(input logic wr, input logic [1:0] b, input logic [11:0] r, input logic [8:0] c,
                      input logic [63:0] d, input logic [7:0] m);
    int t;
    logic [20:0] key;
    key = {b, r, c[8:2]};
    t = 0;
    @(posedge clk);
    wr_req <= wr;
    rd_req <= !wr;
    {req_bank, req_row, req_col, wr_data, wr_mask} <= {b, r, c, d, m};
    do begin
      @(posedge clk);
      t++;
    end while (!(req_ready === 1'b1 && ce === 1'b1) && t < 4000);
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    if (t >= 4000) timeout();
    if (wr) shadow[key] = merge(shadow.exists(key) ? shadow[key] : 64'h0, d, m);
    else begin
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (rd_valid !== 1'b1 && t < 400);
      if (t >= 400) timeout();
      got = rd_data;
      check(got, shadow.exists(key) ? shadow[key] : 64'h0);
      // the pulse is frozen with the rest of the state while ce is low
      t = 0;
      while (ce !== 1'b1 && t < 400) begin
        @(posedge clk);
        t++;
      end
      if (t >= 400) timeout();
      @(posedge clk);
      check({63'h0, rd_valid}, 64'h0);
    end
  endtask

  // ==========================================
  // main sequence
  initial begin
    seed = 32'h488b_cdf7;
    {sys_rst, ce, rand_ce, wr_req, rd_req} = 5'b11000;
    {req_bank, req_row, req_col, wr_data, wr_mask} = '0;
    {error_cnt, samples_checked} = {32'h0, 32'h0};
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    wr_req <= 1'b1;
    repeat (300) @(posedge clk);
    check({63'h0, req_ready}, 64'h0);
    check(64'(wr_cmds), 64'h0);
    wr_req <= 1'b0;
    n = 0;
    while (init_done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) timeout();
    $display("test power-up done");
    // every bank, one of the last four rows and the last column group, then a fully masked write
    for (k = 0; k < 4; k++) xfer(1'b1, k[1:0], 12'hfff - 12'(k), 9'h1fc + 9'(k), {$random(seed), $random(seed)}, 8'h00);
    xfer(1'b1, 2'h0, 12'hfff, 9'h1fc, {$random(seed), $random(seed)}, 8'hff);
    for (k = 0; k < 4; k++) xfer(1'b0, k[1:0], 12'hfff - 12'(k), 9'h1fc, 64'h0, 8'h00);
    check({63'h0, rd_strobe_seen}, 64'h1);
    $display("test corners done");
    // random traffic over four rows per bank at any column group, so masks meet old data
    for (k = 0; k < 24; k++) begin
      rand_ce = k[3];
      xfer(1'($random(seed)), 2'($random(seed)), 12'($random(seed) & 3), 9'($random(seed)),
           {$random(seed), $random(seed)}, ($random(seed) & 1) ? 8'($random(seed)) : 8'h00);
    end
    rand_ce = 1'b0;
    $display("test random done");
    // a read asked for while busy is dropped, not queued
    xfer(1'b1, 2'h1, 12'h002, 9'h010, 64'h0123_4567_89ab_cdef, 8'h5a);
    n = rd_cmds;
    @(posedge clk);
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
    xfer(1'b0, 2'h1, 12'h002, 9'h010, 64'h0, 8'h00);
    check(64'(rd_cmds - n), 64'h1);
    $display("test refused done");
    // idle long enough for many refreshes
    repeat (900) @(posedge clk);
    xfer(1'b0, 2'h3, 12'hffc, 9'h1fc, 64'h0, 8'h00);
    check(64'(viol), 64'h0);
    $display("test refresh done");
    final_report();
  end
endmodule

// ==== tb/mdp_mem_model.sv ====
`timescale 1ns/1ps
// ==========================================
// behavioural x16 mobile ddr part
module mdp_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_clk_p,
  input  wire logic        mem_clk_n,
  input  wire logic        mem_cke,
  input  wire logic [3:0]  cmd_pins,
  input  wire logic [12:0] mem_addr,
  input  wire logic [1:0]  mem_bank,
  input  wire logic [15:0] mem_dq_out,
  input  wire logic        mem_dq_oe_n,
  input  wire logic [1:0]  dqs_out,
  input  wire logic [1:0]  dqs_oe_n,
  input  wire logic [1:0]  wmask,
  output logic      [15:0] mem_dq_in,
  output logic      [1:0]  dqs_in,
  output int               viol,
  output int               rd_cmds,
  output int               wr_cmds
);
  logic [15:0] cells [logic [22:0]];  // {bank, row, col} of 16-bit words
  logic [11:0] open_row [4];
  logic [22:0] rd_base, wr_base, k, wk;
  logic [15:0] drv, w;
  logic        drv_on, dqs_drv, dqs_last, ref_seen, mode_ok;
  logic [1:0]  wr_beat;
  int          rd_h, since_act, since_pre, since_ref;

  // ==========================================
  // wire level: a released line shows a changing pattern, not old data
  assign mem_dq_in = !mem_dq_oe_n ? mem_dq_out : drv;
  assign dqs_in[0] = !dqs_oe_n[0] ? dqs_out[0] : dqs_drv;
  assign dqs_in[1] = !dqs_oe_n[1] ? dqs_out[1] : dqs_drv;

  // start idle with no mode programmed
  initial begin
    {viol, rd_cmds, wr_cmds, rd_h} = {32'h0, 32'h0, 32'h0, 32'h63};
    {drv, drv_on, dqs_drv, dqs_last, ref_seen, mode_ok} = 21'h0;
  end

  // ==========================================
  // commands on rising memory clock, read data on both edges
  always @(mem_clk_p) begin
    if (rd_h < 99) rd_h++;
    k = {rd_base[22:2], 2'(rd_h - 6)};
    drv_on = (rd_h >= 6 && rd_h <= 9);  // latency 3, burst of 4
    drv = drv_on ? (cells.exists(k) ? cells[k] : 16'h0000) : ~drv;
    dqs_drv = drv_on ? ~rd_h[0] : ~dqs_drv;
    if (mem_clk_p === 1'b1) begin
      since_act++;
      since_pre++;
      since_ref++;
      if (mem_clk_n !== 1'b0) viol++;
      if (mem_cke !== 1'b1) {ref_seen, mode_ok} = 2'h0;
      if (ref_seen && since_ref > 110) viol++;
      case (cmd_pins)
        4'h3: begin
          if (since_pre < 3 || mem_addr[12]) viol++;
          open_row[mem_bank] = mem_addr[11:0];
          since_act = 0;
        end
        4'h4, 4'h5: begin
          if (!mode_ok || since_act < 3) viol++;
          if (cmd_pins[0]) begin
            rd_base = {mem_bank, open_row[mem_bank], mem_addr[8:0]};
            rd_h = 0;
            rd_cmds++;
          end else begin
            wr_base = {mem_bank, open_row[mem_bank], mem_addr[8:0]};
            wr_beat = 2'h0;
            wr_cmds++;
          end
        end
        4'h2: since_pre = 0;
        4'h1: begin
          ref_seen = 1'b1;
          since_ref = 0;
        end
        4'h0: if (mem_bank == 2'h0) begin
          mode_ok = (mem_addr[2:0] == 3'h2 && mem_addr[6:4] == 3'h3);
          if (!mode_ok) viol++;
        end
        default: ;
      endcase
    end
  end

  // ==========================================
  // write beats taken on each strobe change, away from the launching edge
  always @(negedge clk) begin
    if (mem_dq_oe_n === 1'b0 && dqs_out[0] !== dqs_last) begin
      wk = {wr_base[22:2], wr_beat};
      w = cells.exists(wk) ? cells[wk] : 16'h0000;
      if (dqs_out[1] !== dqs_out[0]) viol++;
      if (!wmask[0]) w[7:0] = mem_dq_out[7:0];  // each lane masked alone
      if (!wmask[1]) w[15:8] = mem_dq_out[15:8];
      cells[wk] = w;  // kept until overwritten
      wr_beat++;
    end
    dqs_last = mem_dq_oe_n ? 1'b0 : dqs_out[0];
  end
endmodule
